// >>> hdl/dxm_defines.vh
// Constants for the dual external memory port.
// Assumes inclusion by bare name from the design files.
`ifndef DXM_DEFINES_VH
`define DXM_DEFINES_VH
`define DXM_PA_W 24
`define DXM_PD_W 48
`define DXM_PBANKS 2
`define DXM_DA_W 32
`define DXM_DD_W 40
`define DXM_DBANKS 4
`define DXM_WAIT_W 3
`define DXM_WORD32_LSB_P 16
`define DXM_WORD32_LSB_D 8
`define DXM_ST_IDLE 2'h0
`define DXM_ST_WAIT 2'h1
`define DXM_ST_HOLD 2'h2
`define DXM_ST_DONE 2'h3
`endif

// >>> hdl/dxm_port.v
// One external memory port: decode, strobes, wait states, float control.
// Assumes a core-side request held until done_o; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "dxm_defines.vh"
module dxm_port #(
  parameter AW = 24,
  parameter DW = 48,
  parameter NB = 2,
  parameter WW = 3
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // Core side
  input wire req_i,
  input wire wr_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  input wire [NB*AW-1:0] bank_base_i,
  input wire [NB*WW-1:0] bank_wait_i,
  input wire [AW-1:0] page_mask_i,
  output reg [DW-1:0] rdata_o,
  output wire done_o,
  output wire halted_o,
  // Pins
  output reg [AW-1:0] addr_o,
  output reg [AW-1:0] addr_oe_o,
  output reg [DW-1:0] data_o,
  output wire [DW-1:0] data_oe_o,
  input wire [DW-1:0] data_i,
  output wire [NB-1:0] bank_sel_n_o,
  output wire [NB-1:0] bank_sel_oe_o,
  output wire rd_n_o,
  output wire wr_n_o,
  output wire strobe_oe_o,
  input wire ack_i,
  input wire float_n_i,
  output reg page_cross_o
);
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [WW-1:0] cnt_q;
  reg [WW-1:0] cnt_d;
  reg wr_q;
  reg [AW-1:0] last_page_q;
  reg [NB-1:0] hit;
  reg [WW-1:0] wsel;
  wire active;
  wire drive;
  integer b;
  // Decoded from the registered address; selects assert only with the strobes
  always @* begin
    hit = {NB{1'b0}};
    wsel = {WW{1'b0}};
    for (b = NB-1; b >= 0; b = b - 1) begin
      if (addr_o >= bank_base_i[b*AW +: AW] && hit == {NB{1'b0}}) begin
        hit[b] = 1'b1;
        wsel = bank_wait_i[b*WW +: WW];
      end
    end
  end
  assign active = (st_q == `DXM_ST_WAIT);
  assign drive = float_n_i;
  assign bank_sel_n_o = ~(hit & {NB{active}});
  assign bank_sel_oe_o = {NB{drive}};
  assign rd_n_o = ~(active & ~wr_q);
  assign wr_n_o = ~(active & wr_q);
  assign strobe_oe_o = drive;
  // Address must let go in the same cycle as the strobes
  always @* begin
    addr_oe_o = {AW{drive}};
  end
  assign data_oe_o = {DW{drive & active & wr_q}};
  assign done_o = (st_q == `DXM_ST_DONE);
  assign halted_o = (st_q == `DXM_ST_HOLD);
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      `DXM_ST_IDLE: begin
        if (req_i) begin
          st_d = `DXM_ST_WAIT;
          cnt_d = {WW{1'b0}};
        end
      end
      `DXM_ST_WAIT: begin
        if (!float_n_i) begin
          st_d = `DXM_ST_HOLD;
        end else if (cnt_q < wsel) begin
          cnt_d = cnt_q + {{(WW-1){1'b0}}, 1'b1};
        end else if (ack_i) begin
          st_d = `DXM_ST_DONE;
        end
      end
      `DXM_ST_HOLD: begin
        // Access resumes on release; ack then finishes it
        if (float_n_i) begin
          st_d = `DXM_ST_WAIT;
        end
      end
      `DXM_ST_DONE: begin
        st_d = `DXM_ST_IDLE;
      end
      default: begin
        st_d = `DXM_ST_IDLE;
      end
    endcase
  end
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_q <= `DXM_ST_IDLE;
      cnt_q <= {WW{1'b0}};
      wr_q <= 1'b0;
      addr_o <= {AW{1'b0}};
      data_o <= {DW{1'b0}};
      rdata_o <= {DW{1'b0}};
      last_page_q <= {AW{1'b0}};
      page_cross_o <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      page_cross_o <= 1'b0;
      if (st_q == `DXM_ST_IDLE && req_i) begin
        wr_q <= wr_i;
        addr_o <= addr_i;
        data_o <= wdata_i;
        // Page compare on masked upper address bits
        if ((addr_i & page_mask_i) != last_page_q) begin
          page_cross_o <= 1'b1;
        end
        last_page_q <= addr_i & page_mask_i;
      end
      if (st_q == `DXM_ST_WAIT && st_d == `DXM_ST_DONE && !wr_q) begin
        rdata_o <= data_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/dxm_top.v
// Dual external memory port: program port and data port side by side.
// Assumes a core that holds each request until its done pulse.
`timescale 1ns/1ps
`default_nettype none
`include "dxm_defines.vh"
// Summary of operation
// - Highest numbered line of each bus is the most significant bit.
// - Drive 24-bit program address for each program access.
// - Program data bus is 48 bits, two-way; 32-bit words on 47..16.
// - Two program bank selects, banks set by control inputs.
// - Program bank selects decoded combinationally from the address.
// - Program read strobe asserted while reading program memory.
// - Program write strobe asserted while writing program memory.
// - Program access extended while program acknowledge is low.
// - Program page flag set when access crosses a page boundary.
// - Program float input low releases program address, data, selects, strobes.
// - Float during a program access holds it until release.
// - Drive 32-bit data address for each data access.
// - Data bus is 40 bits, two-way; 32-bit words on 39..8.
// - Four data bank selects, ranges set by control inputs.
// - Data bank selects decoded from the data address.
// - Data read and write strobes follow data-memory direction.
// - Data access extended until data acknowledge returns.
// - Data page flag set when access crosses a page boundary.
// - Data float input floats data port and holds access likewise.
module dxm_top (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // Memory control settings
  input wire [`DXM_PBANKS*`DXM_PA_W-1:0] prog_bank_base_i,
  input wire [`DXM_PBANKS*`DXM_WAIT_W-1:0] prog_bank_wait_i,
  input wire [`DXM_PA_W-1:0] prog_page_mask_i,
  input wire [`DXM_DBANKS*`DXM_DA_W-1:0] data_bank_base_i,
  input wire [`DXM_DBANKS*`DXM_WAIT_W-1:0] data_bank_wait_i,
  input wire [`DXM_DA_W-1:0] data_page_mask_i,
  // Core program requests
  input wire prog_req_i,
  input wire prog_wr_i,
  input wire [`DXM_PA_W-1:0] prog_addr_i,
  input wire [`DXM_PD_W-1:0] prog_wdata_i,
  output wire [`DXM_PD_W-1:0] prog_rdata_o,
  output wire prog_done_o,
  output wire prog_halted_o,
  // Core data requests
  input wire data_req_i,
  input wire data_wr_i,
  input wire [`DXM_DA_W-1:0] data_addr_i,
  input wire [`DXM_DD_W-1:0] data_wdata_i,
  output wire [`DXM_DD_W-1:0] data_rdata_o,
  output wire data_done_o,
  output wire data_halted_o,
  // Program port pins
  output wire [`DXM_PA_W-1:0] prog_addr_out_o,
  output wire [`DXM_PA_W-1:0] prog_addr_out_oe_o,
  output wire [`DXM_PD_W-1:0] prog_data_bus_o,
  output wire [`DXM_PD_W-1:0] prog_data_bus_oe_o,
  input wire [`DXM_PD_W-1:0] prog_data_bus_i,
  output wire [`DXM_PBANKS-1:0] prog_bank_sel_n_o,
  output wire [`DXM_PBANKS-1:0] prog_bank_sel_oe_o,
  output wire prog_read_strobe_n_o,
  output wire prog_write_strobe_n_o,
  output wire prog_strobe_oe_o,
  input wire prog_ack_in_i,
  input wire prog_port_float_n_i,
  output wire prog_page_cross_o,
  // Data port pins
  output wire [`DXM_DA_W-1:0] data_addr_out_o,
  output wire [`DXM_DA_W-1:0] data_addr_out_oe_o,
  output wire [`DXM_DD_W-1:0] data_bus_io_o,
  output wire [`DXM_DD_W-1:0] data_bus_io_oe_o,
  input wire [`DXM_DD_W-1:0] data_bus_io_i,
  output wire [`DXM_DBANKS-1:0] data_bank_sel_n_o,
  output wire [`DXM_DBANKS-1:0] data_bank_sel_oe_o,
  output wire data_read_strobe_n_o,
  output wire data_write_strobe_n_o,
  output wire data_strobe_oe_o,
  input wire data_ack_in_i,
  input wire data_port_float_n_i,
  output wire data_page_cross_o
);
  // Program port; ports run independently, a float on one leaves the other
  dxm_port #(
    .AW(`DXM_PA_W),
    .DW(`DXM_PD_W),
    .NB(`DXM_PBANKS),
    .WW(`DXM_WAIT_W)
  ) u_prog (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .req_i(prog_req_i),
    .wr_i(prog_wr_i),
    .addr_i(prog_addr_i),
    .wdata_i(prog_wdata_i),
    .bank_base_i(prog_bank_base_i),
    .bank_wait_i(prog_bank_wait_i),
    .page_mask_i(prog_page_mask_i),
    .rdata_o(prog_rdata_o),
    .done_o(prog_done_o),
    .halted_o(prog_halted_o),
    .addr_o(prog_addr_out_o),
    .addr_oe_o(prog_addr_out_oe_o),
    .data_o(prog_data_bus_o),
    .data_oe_o(prog_data_bus_oe_o),
    .data_i(prog_data_bus_i),
    .bank_sel_n_o(prog_bank_sel_n_o),
    .bank_sel_oe_o(prog_bank_sel_oe_o),
    .rd_n_o(prog_read_strobe_n_o),
    .wr_n_o(prog_write_strobe_n_o),
    .strobe_oe_o(prog_strobe_oe_o),
    .ack_i(prog_ack_in_i),
    .float_n_i(prog_port_float_n_i),
    .page_cross_o(prog_page_cross_o)
  );
  // Data port
  dxm_port #(
    .AW(`DXM_DA_W),
    .DW(`DXM_DD_W),
    .NB(`DXM_DBANKS),
    .WW(`DXM_WAIT_W)
  ) u_data (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .req_i(data_req_i),
    .wr_i(data_wr_i),
    .addr_i(data_addr_i),
    .wdata_i(data_wdata_i),
    .bank_base_i(data_bank_base_i),
    .bank_wait_i(data_bank_wait_i),
    .page_mask_i(data_page_mask_i),
    .rdata_o(data_rdata_o),
    .done_o(data_done_o),
    .halted_o(data_halted_o),
    .addr_o(data_addr_out_o),
    .addr_oe_o(data_addr_out_oe_o),
    .data_o(data_bus_io_o),
    .data_oe_o(data_bus_io_oe_o),
    .data_i(data_bus_io_i),
    .bank_sel_n_o(data_bank_sel_n_o),
    .bank_sel_oe_o(data_bank_sel_oe_o),
    .rd_n_o(data_read_strobe_n_o),
    .wr_n_o(data_write_strobe_n_o),
    .strobe_oe_o(data_strobe_oe_o),
    .ack_i(data_ack_in_i),
    .float_n_i(data_port_float_n_i),
    .page_cross_o(data_page_cross_o)
  );
endmodule
`default_nettype wire

// >>> verif/dxm_top_sva.sv
// Pin checker for dxm_top.
// Assumes binding to dxm_top; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module dxm_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Program port
  input wire logic prog_ack_in_i,
  input wire logic prog_port_float_n_i,
  input wire logic prog_read_strobe_n_o,
  input wire logic prog_write_strobe_n_o,
  input wire logic prog_strobe_oe_o,
  input wire logic [1:0] prog_bank_sel_oe_o,
  input wire logic [47:0] prog_data_bus_oe_o,
  input wire logic [23:0] prog_addr_out_oe_o,
  input wire logic prog_done_o,
  input wire logic prog_halted_o,
  // Data port
  input wire logic data_ack_in_i,
  input wire logic data_port_float_n_i,
  input wire logic data_read_strobe_n_o,
  input wire logic data_write_strobe_n_o,
  input wire logic data_strobe_oe_o,
  input wire logic [3:0] data_bank_sel_oe_o,
  input wire logic [39:0] data_bus_io_oe_o,
  input wire logic [31:0] data_addr_out_oe_o,
  input wire logic data_done_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_prog_one_strobe: assert property (
    prog_read_strobe_n_o | prog_write_strobe_n_o) else $error("pm strobes");
  a_data_one_strobe: assert property (
    data_read_strobe_n_o | data_write_strobe_n_o) else $error("dm strobes");
  a_prog_float_off: assert property (!prog_port_float_n_i |->
    !prog_strobe_oe_o && prog_bank_sel_oe_o == 2'h0
    && prog_data_bus_oe_o == 48'h0 && prog_addr_out_oe_o == 24'h0)
    else $error("pm float");
  a_data_float_off: assert property (
    !data_port_float_n_i |-> !data_strobe_oe_o
    && data_bank_sel_oe_o == 4'h0 && data_bus_io_oe_o == 40'h0
    && data_addr_out_oe_o == 32'h0) else $error("dm float");
  a_prog_ack_wait: assert property (!prog_ack_in_i &&
    !(prog_read_strobe_n_o && prog_write_strobe_n_o) |=> !prog_done_o)
    else $error("pm ack");
  a_data_ack_wait: assert property (!data_ack_in_i &&
    !(data_read_strobe_n_o && data_write_strobe_n_o) |=> !data_done_o)
    else $error("dm ack");
  a_prog_write_drive: assert property (!prog_write_strobe_n_o &&
    prog_port_float_n_i |-> &prog_data_bus_oe_o) else $error("pm write");
  a_prog_read_free: assert property (!prog_read_strobe_n_o |->
    prog_data_bus_oe_o == 48'h0) else $error("pm read");
  a_prog_halt_quiet: assert property (prog_halted_o |->
    prog_read_strobe_n_o && prog_write_strobe_n_o && !prog_done_o)
    else $error("pm halt");
  a_prog_done_cause: assert property (prog_done_o |->
    $past(prog_ack_in_i) && !($past(prog_read_strobe_n_o)
    && $past(prog_write_strobe_n_o))) else $error("pm done");
endmodule
bind dxm_top dxm_chk u_chk (.*);
`default_nettype wire

// >>> verif/dxm_mem.sv
// Behavioural memory on one port of dxm_top.
// Assumes active-low strobes, address held through the access.
`timescale 1ns/1ps
`default_nettype none
module dxm_mem #(
  parameter int AW = 24,
  parameter int DW = 48
) (
  // Pins
  input wire logic clk_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  // Control
  input wire logic slow_i,
  output logic ack_o,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [0:15];
  logic [DW-1:0] last_q = '0;
  logic [1:0] cnt_q = 2'h0;
  // Slow holds ack off two cycles; float test runs fast
  assign ack_o = !slow_i || cnt_q == 2'h2;
  // Released lines toggle so no stale value passes
  assign rdata_o = rd_n_i ? ~last_q : mem_q[addr_i[3:0]];
  always @(posedge clk_i) begin
    last_q <= rdata_o;
    cnt_q <= (rd_n_i && wr_n_i) ? 2'h0 : cnt_q + {1'b0, cnt_q != 2'h2};
    if (!wr_n_i && ack_o) begin
      mem_q[addr_i[3:0]] <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// >>> verif/dxm_top_tb.sv
// Testbench for dxm_top with memory models on both ports.
// Assumes dxm_mem and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module dxm_top_tb;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, pslow = 1'b0, dslow = 1'b0;
  logic [47:0] prog_bank_base_i = 48'h800000_000000, prog_wdata_i = '0;
  logic [5:0] prog_bank_wait_i = '0;
  logic [23:0] prog_page_mask_i = 24'hfff000, prog_addr_i = '0;
  logic [127:0] data_bank_base_i = 128'hc0000000800000004000000000000000;
  logic [11:0] data_bank_wait_i = '0;
  logic [31:0] data_page_mask_i = 32'hffff0000, data_addr_i = '0;
  logic prog_req_i = 0, prog_wr_i = 0, data_req_i = 0, data_wr_i = 0;
  logic prog_port_float_n_i = 1, data_port_float_n_i = 1;
  logic [39:0] data_wdata_i = '0;
  wire [47:0] prog_rdata_o, prog_data_bus_o, prog_data_bus_oe_o;
  wire [47:0] prog_data_bus_i, pmq;
  wire [39:0] data_rdata_o, data_bus_io_o, data_bus_io_oe_o;
  wire [39:0] data_bus_io_i, dmq;
  wire [23:0] prog_addr_out_o, prog_addr_out_oe_o;
  wire [31:0] data_addr_out_o, data_addr_out_oe_o;
  wire [1:0] prog_bank_sel_n_o, prog_bank_sel_oe_o;
  wire [3:0] data_bank_sel_n_o, data_bank_sel_oe_o;
  wire prog_done_o, prog_halted_o, prog_read_strobe_n_o, prog_strobe_oe_o;
  wire prog_write_strobe_n_o, prog_ack_in_i, prog_page_cross_o;
  wire data_done_o, data_halted_o, data_read_strobe_n_o, data_strobe_oe_o;
  wire data_write_strobe_n_o, data_ack_in_i, data_page_cross_o;
  int n, miscompares = 0, num_checks = 0;
  logic [47:0] rd;
  logic [31:0] ad;
  logic [3:0] sel;
  logic pg, hlt;
  // Pin level from the DUT's enables; the memory model drives wherever they are off
  assign prog_data_bus_i = prog_data_bus_oe_o & prog_data_bus_o
    | ~prog_data_bus_oe_o & pmq;
  assign data_bus_io_i = data_bus_io_oe_o & data_bus_io_o
    | ~data_bus_io_oe_o & dmq;
  dxm_top DUT (.*);
  dxm_mem #(.AW(24), .DW(48)) u_pm (.clk_i(clk_sys_i),
    .rd_n_i(prog_read_strobe_n_o), .wr_n_i(prog_write_strobe_n_o),
    .addr_i(prog_addr_out_o), .wdata_i(prog_data_bus_i),
    .slow_i(pslow), .ack_o(prog_ack_in_i), .rdata_o(pmq));
  dxm_mem #(.AW(32), .DW(40)) u_dm (.clk_i(clk_sys_i),
    .rd_n_i(data_read_strobe_n_o), .wr_n_i(data_write_strobe_n_o),
    .addr_i(data_addr_out_o), .wdata_i(data_bus_io_i),
    .slow_i(dslow), .ack_o(data_ack_in_i), .rdata_o(dmq));
  always #50 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [47:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic p, w, input logic [47:0] a, d);
    if (p) begin
      {prog_req_i, prog_wr_i, prog_addr_i} <= {1'b1, w, a[23:0]};
      prog_wdata_i <= d;
    end else begin
      {data_req_i, data_wr_i, data_addr_i} <= {1'b1, w, a[31:0]};
      data_wdata_i <= d[39:0];
    end
    {n, pg, hlt} = '0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
      if (p ? !(prog_read_strobe_n_o & prog_write_strobe_n_o)
          : !(data_read_strobe_n_o & data_write_strobe_n_o)) begin
        sel = p ? {2'h3, prog_bank_sel_n_o} : data_bank_sel_n_o;
        ad = p ? {8'h0, prog_addr_out_o} : data_addr_out_o;
      end
      pg |= p ? prog_page_cross_o : data_page_cross_o;
      hlt |= p ? prog_halted_o & !prog_strobe_oe_o
        : data_halted_o & !data_strobe_oe_o;
    end while (!(p ? prog_done_o : data_done_o) && n < 40);
    if (n >= 40) miscompares++;
    rd = p ? prog_rdata_o : {8'h0, data_rdata_o};
    @(posedge clk_sys_i);
    prog_req_i <= 1'b0;
    data_req_i <= 1'b0;
    // Idle edge so the next call never re-raises req in the same step
    @(posedge clk_sys_i);
  endtask
  task automatic t_prog;
    acc(1, 1, 48'h10, 48'h8000_1234_5678);
    chk(n, 2);
    acc(1, 0, 48'h10, 0);
    chk(rd, 48'h8000_1234_5678);
    chk({pg, sel, ad}, {1'b0, 4'he, 32'h10});
    acc(1, 1, 48'h801011, 48'h1);
    chk({pg, sel, ad}, {1'b1, 4'hd, 32'h801011});
  endtask
  task automatic t_data;
    acc(0, 1, 48'hc0000008, 48'h80_dead_beef);
    acc(0, 0, 48'hc0000008, 0);
    chk(rd, 48'h80_dead_beef);
    chk({pg, sel, ad}, {1'b0, 4'h7, 32'hc0000008});
    acc(0, 1, 48'h1, 48'h5);
    chk({pg, sel}, {1'b1, 4'he});
  endtask
  task automatic t_wait;
    prog_bank_wait_i <= 6'h7;
    acc(1, 0, 48'h10, 0);
    chk(n, 9);
    {prog_bank_wait_i, pslow} <= {6'h0, 1'b1};
    acc(1, 0, 48'h10, 0);
    chk(n, 4);
    {data_bank_wait_i, pslow} <= {12'h005, 1'b0};
    acc(0, 1, 48'h1, 48'h5);
    chk(n, 7);
    {data_bank_wait_i, dslow} <= {12'h0, 1'b1};
    acc(0, 0, 48'h1, 0);
    chk(n, 4);
    chk(rd, 48'h5);
    dslow <= 1'b0;
  endtask
  task automatic t_float(input logic p);
    if (p) prog_bank_wait_i <= 6'h3;
    else data_bank_wait_i <= 12'h3;
    fork
      acc(p, 0, p ? 48'h10 : 48'h1, 0);
      begin
        repeat (2) @(posedge clk_sys_i);
        if (p) prog_port_float_n_i <= 1'b0;
        else data_port_float_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        prog_port_float_n_i <= 1'b1;
        data_port_float_n_i <= 1'b1;
      end
    join
    chk(n, 9);
    chk({hlt, rd}, {1'b1, p ? 48'h8000_1234_5678 : 48'h5});
  endtask
  task automatic conclude;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_prog;
    t_data;
    t_wait;
    t_float(1);
    t_float(0);
    conclude;
  end
  initial begin
    #200000;
    miscompares++;
    conclude;
  end
endmodule
`default_nettype wire
